// ==== logic/doze_idle_watchdog_control.sv ====
// cpu power-down control (idle, sleep, doze) and watchdog timer
// assumes cpu event inputs synchronous to clk_sys_i; one Avalon-MM slave
//
// Function
// R1 - idle select: sleep stops only cpu clock
// R2 - idle clear: sleep stops cpu and system
// R3 - slow enable: one cpu cycle per ratio
// R4 - recover-on-interrupt clears slow enable on isr
// R5 - slow-on-exit sets slow enable on return
// R6 - ratio codes 000..111 give 1:2..1:256
// R7 - debugger forces full speed, bit kept
// R8 - watchdog resets unless cleared in time
// R9 - time-out selectable 1 ms to 256 s
// R10 - watchdog counts 31 kHz oscillator ticks
// R11 - mode 11: always active, even sleeping
// R12 - mode 10: active awake, off in sleep
// R13 - mode 01: follows software enable bit
// R14 - mode 00: disabled, enable bit ignored
// R15 - any interrupt ends idle, select kept
// R16 - time-out while down wakes, no recover
// R17 - disabled or cleared watchdog restarts zero
`timescale 1ns/100ps

module doze_idle_watchdog_control (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // avalon-mm slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // core side
  input wire doze_idle_watchdog_pkg::cpu_events_t cpu_events_i,
  output doze_idle_watchdog_pkg::clock_ctl_t clock_ctl_o,
  output logic watchdog_reset_o,
  output logic wake_o,
  output logic irq_o
);

  // ==========================================================================
  // registers and state
  logic [7:0] doze_idle_control;
  logic [7:0] watchdog_control;
  logic [1:0] watchdog_mode_cfg;
  logic [4:0] irq_status;
  logic [4:0] irq_mask;
  doze_idle_watchdog_pkg::power_state_t power_state;
  logic ack;
  logic [10:0] lfo_div;
  logic lfo_tick;
  logic [22:0] wdt_count;
  logic [7:0] doze_count;

  logic bus_req;
  logic wr_en;
  logic rd_en;
  logic [7:0] wr_byte;
  logic sleep_accept;
  logic int_wake;
  logic wdt_active;
  logic wdt_expire;
  logic wdt_timeout;
  logic wdt_wake;
  logic wdt_clear;
  logic down;
  logic [4:0] period_sel;
  logic [4:0] prescale_shift;
  logic [22:0] wdt_terminal;
  logic [7:0] doze_last;
  logic [4:0] irq_events;
  logic [31:0] next_readdata;

  // ==========================================================================
  // bus slave: one wait state on every access
  assign bus_req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = bus_req & ~ack;
  // the access completes on the edge where waitrequest is low
  assign wr_en = avs_write_i & ack & avs_byteenable_i[0];
  assign rd_en = avs_read_i & ~ack;
  assign wr_byte = avs_writedata_i[7:0];

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack <= 1'b0;
    end else begin
      ack <= bus_req & ~ack;
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    case (avs_address_i)
      doze_idle_watchdog_pkg::ADDR_DOZE_IDLE: begin
        next_readdata[7:0] = doze_idle_control;
      end
      doze_idle_watchdog_pkg::ADDR_WATCHDOG: begin
        next_readdata[7:0] = watchdog_control;
      end
      doze_idle_watchdog_pkg::ADDR_WDT_MODE: begin
        next_readdata[1:0] = watchdog_mode_cfg;
      end
      doze_idle_watchdog_pkg::ADDR_IRQ_STATUS: begin
        next_readdata[4:0] = irq_status;
      end
      doze_idle_watchdog_pkg::ADDR_IRQ_MASK: begin
        next_readdata[4:0] = irq_mask;
      end
      doze_idle_watchdog_pkg::ADDR_POWER_STATE: begin
        next_readdata[1:0] = power_state;
      end
      default: begin
        next_readdata = 32'h0000_0000;
      end
    endcase
  end

  // data is captured in the wait cycle so it stands on the completing edge
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_en) begin
      avs_readdata_o <= next_readdata;
    end
  end

  // ==========================================================================
  // doze/idle control register
  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      doze_idle_control <= doze_idle_watchdog_pkg::DOZE_IDLE_RESET;
    end else begin
      if (wr_en && avs_address_i == doze_idle_watchdog_pkg::ADDR_DOZE_IDLE) begin
        doze_idle_control <= wr_byte & doze_idle_watchdog_pkg::DOZE_IDLE_WMASK;
      end
      if (cpu_events_i.isr_entry &&
          doze_idle_control[doze_idle_watchdog_pkg::RECOVER_ON_INT_BIT]) begin
        doze_idle_control[doze_idle_watchdog_pkg::SLOW_CPU_ENABLE_BIT] <=
          1'b0; // R4
      end
      if (cpu_events_i.return_from_isr &&
          doze_idle_control[doze_idle_watchdog_pkg::SLOW_ON_EXIT_BIT]) begin
        doze_idle_control[doze_idle_watchdog_pkg::SLOW_CPU_ENABLE_BIT] <=
          1'b1; // R5
      end
    end
  end

  // ==========================================================================
  // watchdog control and mode configuration
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      watchdog_control <= doze_idle_watchdog_pkg::WATCHDOG_RESET;
    end else if (wr_en &&
                 avs_address_i == doze_idle_watchdog_pkg::ADDR_WATCHDOG) begin
      watchdog_control <= wr_byte & doze_idle_watchdog_pkg::WATCHDOG_WMASK;
    end
  end

  // mode stands in for the fuse word, so software may load it
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      watchdog_mode_cfg <= doze_idle_watchdog_pkg::WDT_MODE_RESET;
    end else if (wr_en &&
                 avs_address_i == doze_idle_watchdog_pkg::ADDR_WDT_MODE) begin
      watchdog_mode_cfg <= wr_byte[1:0];
    end
  end

  // ==========================================================================
  // power state
  // a pending interrupt turns sleep into a no-op
  assign sleep_accept = cpu_events_i.sleep_instr &
                        ~cpu_events_i.interrupt_pending &
                        power_state == doze_idle_watchdog_pkg::PWR_AWAKE;
  assign down = power_state != doze_idle_watchdog_pkg::PWR_AWAKE;
  // wakes regardless of global interrupt enable
  assign int_wake = down & cpu_events_i.interrupt_pending; // R15
  assign wdt_wake = down & wdt_expire & ~int_wake; // R16

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      power_state <= doze_idle_watchdog_pkg::PWR_AWAKE;
    end else begin
      case (power_state)
        doze_idle_watchdog_pkg::PWR_AWAKE: begin
          if (sleep_accept) begin
            if (doze_idle_control[doze_idle_watchdog_pkg::IDLE_SELECT_BIT]) begin
              power_state <= doze_idle_watchdog_pkg::PWR_IDLE; // R1
            end else begin
              power_state <= doze_idle_watchdog_pkg::PWR_SLEEP; // R2
            end
          end
        end
        doze_idle_watchdog_pkg::PWR_IDLE,
        doze_idle_watchdog_pkg::PWR_SLEEP: begin
          if (int_wake || wdt_wake) begin
            power_state <= doze_idle_watchdog_pkg::PWR_AWAKE; // R15 R16
          end
        end
        default: begin
          power_state <= doze_idle_watchdog_pkg::PWR_AWAKE;
        end
      endcase
    end
  end

  // ==========================================================================
  // doze: cpu cycle enable every 2^(code+1) peripheral cycles
  assign doze_last = 8'((9'h002 << doze_idle_control[2:0]) - 9'h001); // R6

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      doze_count <= 8'h00;
    end else if (doze_count >= doze_last) begin
      doze_count <= 8'h00;
    end else begin
      doze_count <= doze_count + 8'h01;
    end
  end

  always_comb begin
    clock_ctl_o.periph_clock_en =
      power_state != doze_idle_watchdog_pkg::PWR_SLEEP; // R1 R2
    clock_ctl_o.cpu_clock_en =
      power_state == doze_idle_watchdog_pkg::PWR_AWAKE; // R1 R2
    // debugger overrides speed but the stored enable is left alone
    if (cpu_events_i.in_circuit_debugger ||
        !doze_idle_control[doze_idle_watchdog_pkg::SLOW_CPU_ENABLE_BIT]) begin
      clock_ctl_o.cpu_cycle_en = clock_ctl_o.cpu_clock_en; // R3 R7
    end else begin
      clock_ctl_o.cpu_cycle_en =
        clock_ctl_o.cpu_clock_en & (doze_count == doze_last); // R3
    end
  end

  // ==========================================================================
  // low-frequency oscillator tick, derived by division from the system clock
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lfo_div <= 11'h000;
    end else if (lfo_div == doze_idle_watchdog_pkg::LFO_LAST) begin
      lfo_div <= 11'h000;
    end else begin
      lfo_div <= lfo_div + 11'h001;
    end
  end
  assign lfo_tick = lfo_div == doze_idle_watchdog_pkg::LFO_LAST; // R10

  // ==========================================================================
  // watchdog
  always_comb begin
    case (watchdog_mode_cfg)
      doze_idle_watchdog_pkg::WDT_MODE_ON: begin
        wdt_active = 1'b1; // R11
      end
      doze_idle_watchdog_pkg::WDT_MODE_AWAKE: begin
        wdt_active = power_state != doze_idle_watchdog_pkg::PWR_SLEEP; // R12
      end
      doze_idle_watchdog_pkg::WDT_MODE_SW: begin
        wdt_active =
          watchdog_control[doze_idle_watchdog_pkg::SW_WDT_ENABLE_BIT]; // R13
      end
      default: begin
        wdt_active = 1'b0; // R14
      end
    endcase
  end

  // reserved period codes fall back to the shortest interval
  assign period_sel = watchdog_control[5:1];
  assign prescale_shift =
    (period_sel > doze_idle_watchdog_pkg::PERIOD_SEL_MAX) ?
    doze_idle_watchdog_pkg::PRESCALE_MIN_SHIFT :
    period_sel + doze_idle_watchdog_pkg::PRESCALE_MIN_SHIFT; // R9
  assign wdt_terminal = 23'((24'h00_0001 << prescale_shift) - 24'h00_0001);

  assign wdt_expire = wdt_active & lfo_tick & (wdt_count == wdt_terminal);
  // while down the time-out wakes the device instead of resetting it
  assign wdt_timeout = wdt_expire & ~down; // R8
  // entering and leaving a low-power state also restart the count
  assign wdt_clear = cpu_events_i.watchdog_clear_instr | sleep_accept |
                     int_wake | wdt_wake | wdt_timeout;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wdt_count <= 23'h00_0000;
    end else if (!wdt_active || wdt_clear) begin
      wdt_count <= 23'h00_0000; // R17
    end else if (lfo_tick) begin
      wdt_count <= wdt_count + 23'h00_0001; // R10
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      watchdog_reset_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      watchdog_reset_o <= wdt_timeout; // R8
      wake_o <= int_wake | wdt_wake; // R15 R16
    end
  end

  // ==========================================================================
  // interrupt status (write one to clear, a new event wins) and mask
  assign irq_events = {int_wake,
                       sleep_accept & doze_idle_control[
                         doze_idle_watchdog_pkg::IDLE_SELECT_BIT],
                       sleep_accept & ~doze_idle_control[
                         doze_idle_watchdog_pkg::IDLE_SELECT_BIT],
                       wdt_wake,
                       wdt_timeout};

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_status <= 5'h00;
    end else if (wr_en &&
                 avs_address_i == doze_idle_watchdog_pkg::ADDR_IRQ_STATUS) begin
      irq_status <= (irq_status & ~wr_byte[4:0]) | irq_events;
    end else begin
      irq_status <= irq_status | irq_events;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_mask <= 5'h00;
    end else if (wr_en &&
                 avs_address_i == doze_idle_watchdog_pkg::ADDR_IRQ_MASK) begin
      irq_mask <= wr_byte[4:0];
    end
  end

  assign irq_o = |(irq_status & irq_mask);

endmodule // doze_idle_watchdog_control

// ==== logic/doze_idle_watchdog_pkg.sv ====
// constants, register map and carrier types for the doze/idle/watchdog block
// assumes a 40 MHz system clock and a 32-bit Avalon-MM register bus
package doze_idle_watchdog_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned LFO_HZ = 31000;
  localparam int unsigned LFO_DIV = CLK_HZ / LFO_HZ;
  localparam logic [10:0] LFO_LAST = 11'(LFO_DIV - 1);

  // ==========================================================================
  // register byte addresses
  localparam logic [4:0] ADDR_DOZE_IDLE = 5'h00;
  localparam logic [4:0] ADDR_WATCHDOG = 5'h04;
  localparam logic [4:0] ADDR_WDT_MODE = 5'h08;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h0c;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h10;
  localparam logic [4:0] ADDR_POWER_STATE = 5'h14;

  // ==========================================================================
  // doze_idle_control fields
  localparam int unsigned IDLE_SELECT_BIT = 7;
  localparam int unsigned SLOW_CPU_ENABLE_BIT = 6;
  localparam int unsigned RECOVER_ON_INT_BIT = 5;
  localparam int unsigned SLOW_ON_EXIT_BIT = 4;
  localparam logic [7:0] DOZE_IDLE_WMASK = 8'hf7;
  localparam logic [7:0] DOZE_IDLE_RESET = 8'h00;

  // watchdog_control fields: period select in bits 5:1, sw enable in bit 0
  localparam int unsigned SW_WDT_ENABLE_BIT = 0;
  localparam logic [7:0] WATCHDOG_WMASK = 8'h3f;
  localparam logic [7:0] WATCHDOG_RESET = 8'h16;
  localparam logic [4:0] PERIOD_SEL_MAX = 5'h12;
  localparam logic [4:0] PRESCALE_MIN_SHIFT = 5'h05;

  localparam logic [1:0] WDT_MODE_RESET = 2'h3;
  localparam logic [1:0] WDT_MODE_OFF = 2'h0;
  localparam logic [1:0] WDT_MODE_SW = 2'h1;
  localparam logic [1:0] WDT_MODE_AWAKE = 2'h2;
  localparam logic [1:0] WDT_MODE_ON = 2'h3;

  // interrupt status / mask bits
  localparam int unsigned IRQ_WDT_RESET = 0;
  localparam int unsigned IRQ_WDT_WAKE = 1;
  localparam int unsigned IRQ_SLEEP_ENTER = 2;
  localparam int unsigned IRQ_IDLE_ENTER = 3;
  localparam int unsigned IRQ_INT_WAKE = 4;
  localparam int unsigned IRQ_BITS = 5;

  typedef enum logic [1:0] {
    PWR_AWAKE,
    PWR_IDLE,
    PWR_SLEEP
  } power_state_t;

  // events from the cpu core, one-cycle pulses except the two levels
  typedef struct packed {
    logic sleep_instr;
    logic watchdog_clear_instr;
    logic isr_entry;
    logic return_from_isr;
    logic interrupt_pending;
    logic in_circuit_debugger;
  } cpu_events_t;

  typedef struct packed {
    logic cpu_clock_en;
    logic periph_clock_en;
    logic cpu_cycle_en;
  } clock_ctl_t;

endpackage

// ==== sim/doze_idle_watchdog_checker.sv ====
// checker for the doze/idle/watchdog block
// assumes the top module ports only, single clock domain
`timescale 1ns/100ps
module doze_idle_watchdog_checker (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire doze_idle_watchdog_pkg::cpu_events_t cpu_events_i,
  input wire doze_idle_watchdog_pkg::clock_ctl_t clock_ctl_o,
  input wire logic watchdog_reset_o,
  input wire logic wake_o
);
  // ==========================================================================
  // properties
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // shortest legal time-out is 31 full ticks after the clear
  localparam int MIN_GAP = 39980;
  logic [16:0] since_clear;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      since_clear <= '0;
    end else if (cpu_events_i.watchdog_clear_instr || watchdog_reset_o ||
                 !clock_ctl_o.cpu_clock_en) begin
      since_clear <= '0;
    end else if (since_clear != '1) begin
      since_clear <= since_clear + 17'h1;
    end
  end
  a_bus_one_wait: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus wait not one cycle");
  a_rdata_upper: assert property (avs_read_i && !avs_waitrequest_o |->
    avs_readdata_o[31:8] == 24'h0) else $error("read data upper bits set");
  a_sleep_stops_cpu: assert property (cpu_events_i.sleep_instr &&
    clock_ctl_o.cpu_clock_en && !cpu_events_i.interrupt_pending |=>
    !clock_ctl_o.cpu_clock_en) else $error("sleep did not stop cpu");
  a_full_sleep: assert property (!clock_ctl_o.periph_clock_en |->
    !clock_ctl_o.cpu_clock_en) else $error("periph off with cpu on");
  a_int_wakes: assert property (cpu_events_i.interrupt_pending &&
    !clock_ctl_o.cpu_clock_en |-> ##[1:2] wake_o)
    else $error("interrupt did not wake");
  a_debug_full: assert property (cpu_events_i.in_circuit_debugger &&
    clock_ctl_o.cpu_clock_en |-> clock_ctl_o.cpu_cycle_en)
    else $error("debugger not at full speed");
  a_reset_awake: assert property (watchdog_reset_o |->
    $past(clock_ctl_o.cpu_clock_en) && !wake_o)
    else $error("watchdog reset while down");
  a_reset_pulse: assert property (watchdog_reset_o |=>
    !watchdog_reset_o [*8]) else $error("watchdog reset too long");
  a_wdt_gap: assert property (watchdog_reset_o |->
    since_clear >= MIN_GAP) else $error("watchdog expired too early");
  a_wake_pulse: assert property (wake_o |=> !wake_o)
    else $error("wake pulse too long");
  c_wake: cover property (wake_o);
  c_wdt_reset: cover property (watchdog_reset_o);
  c_isr: cover property (cpu_events_i.isr_entry);
endmodule // doze_idle_watchdog_checker

bind doze_idle_watchdog_control doze_idle_watchdog_checker u_checker (
  .clk_sys_i, .reset_n_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
  .avs_waitrequest_o, .cpu_events_i, .clock_ctl_o, .watchdog_reset_o,
  .wake_o);

// ==== sim/tb_doze_idle_watchdog_control.sv ====
// self-checking bench for the doze/idle/watchdog block
// assumes the bound checker; reads are compared by a monitor from a queue
`timescale 1ns/100ps
module tb_doze_idle_watchdog_control;
  // ==========================================================================
  // signals
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hf;
  doze_idle_watchdog_pkg::cpu_events_t ev = '0;
  doze_idle_watchdog_pkg::clock_ctl_t clk_ctl;
  logic [31:0] rdata;
  logic waitreq, wdt_rst, wake, irq;
  logic [31:0] exp_q[$];
  logic [7:0] rst_tab [7] = '{8'h00, 8'h16, 8'h03, 8'h00, 8'h00, 8'h00,
                              8'h00};
  logic [7:0] v;
  int n_fail = 0;
  int checks_done = 0;
  int seed = 95;
  int n;
  wire [2:0] watch = {clk_ctl.cpu_cycle_en, wdt_rst, wake};
  always #12.5 clk_sys_i = ~clk_sys_i;
  doze_idle_watchdog_control u_dut (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .cpu_events_i(ev), .clock_ctl_o(clk_ctl), .watchdog_reset_o(wdt_rst),
    .wake_o(wake), .irq_o(irq));
  // ==========================================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wait_on(input int sel, input int lim, output int k);
    k = 0;
    do begin
      @(negedge clk_sys_i);
      k++;
    end while (watch[sel] !== 1'b1 && k < lim);
    if (k >= lim) begin
      n_fail++;
      print_verdict();
    end
  endtask
  // slave answer time is not assumed: wait until waitrequest is low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    int k;
    @(posedge clk_sys_i);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdata <= {24'h0, d};
    if (!w) exp_q.push_back({24'h0, e});
    k = 0;
    // waitrequest is looked at on the rising edge that completes the access
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (waitreq !== 1'b0 && k < 50);
    if (k >= 50) begin
      n_fail++;
      print_verdict();
    end
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic pulse(input int b);
    @(posedge clk_sys_i);
    ev[b] <= 1'b1;
    @(posedge clk_sys_i);
    ev[b] <= 1'b0;
  endtask
  always @(posedge clk_sys_i) begin
    if (rd && waitreq === 1'b0) check(rdata, exp_q.pop_front());
  end
  initial begin
    repeat (96000) @(posedge clk_sys_i);
    n_fail++;
    print_verdict();
  end
  // ==========================================================================
  // scenarios
  initial begin
    repeat (12) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    check(clk_ctl, 3'h7);
    foreach (rst_tab[i]) bus(0, 5'(i * 4), 0, rst_tab[i]);
    repeat (4) begin
      v = 8'($random(seed));
      bus(1, 0, v, 0);
      bus(0, 0, 0, v & 8'hf7);
    end
    be <= 4'h0;
    bus(1, 0, 8'hff, 0);
    be <= 4'hf;
    bus(0, 0, 0, v & 8'hf7);
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      bus(1, 0, 8'h40 | 8'(k), 0);
      repeat (3) wait_on(2, 600, n);
      check(n, 1 << (k + 1));
    end
    bus(1, 0, 8'h07, 0);
    repeat (3) @(negedge clk_sys_i);
    check(clk_ctl.cpu_cycle_en, 1'b1);
    bus(1, 0, 8'h47, 0);
    ev.in_circuit_debugger <= 1'b1;
    repeat (3) @(negedge clk_sys_i);
    check(clk_ctl.cpu_cycle_en, 1'b1);
    @(posedge clk_sys_i);
    ev.in_circuit_debugger <= 1'b0;
    bus(0, 0, 0, 8'h47);
    for (int i = 0; i < 4; i++) begin
      v = 8'h40 | (i[0] ? 8'h20 : 8'h00) | (i[1] ? 8'h10 : 8'h00);
      bus(1, 0, v, 0);
      pulse(3);
      bus(0, 0, 0, i[0] ? v & 8'hbf : v);
      bus(1, 0, v & 8'hbf, 0);
      pulse(2);
      bus(0, 0, 0, i[1] ? v : v & 8'hbf);
    end
    $display("test doze done");
    bus(1, 5'h10, 8'h1f, 0);
    bus(1, 0, 8'h80, 0);
    pulse(5);
    @(negedge clk_sys_i);
    check(clk_ctl[2:1], 2'b01);
    bus(0, 5'h14, 0, 8'h01);
    @(posedge clk_sys_i);
    ev.interrupt_pending <= 1'b1;
    wait_on(0, 10, n);
    check(clk_ctl.cpu_clock_en, 1'b1);
    @(posedge clk_sys_i);
    ev.interrupt_pending <= 1'b0;
    bus(0, 0, 0, 8'h80);
    bus(0, 5'h0c, 0, 8'h18);
    check(irq, 1'b1);
    bus(1, 5'h0c, 8'h18, 0);
    bus(1, 5'h10, 8'h00, 0);
    bus(1, 0, 8'h00, 0);
    pulse(5);
    @(negedge clk_sys_i);
    check(clk_ctl[2:1], 2'b00);
    @(posedge clk_sys_i);
    ev.interrupt_pending <= 1'b1;
    wait_on(0, 10, n);
    pulse(5);
    @(negedge clk_sys_i);
    check(clk_ctl.cpu_clock_en, 1'b1);
    @(posedge clk_sys_i);
    ev.interrupt_pending <= 1'b0;
    bus(0, 5'h0c, 0, 8'h14);
    check(irq, 1'b0);
    bus(1, 5'h10, 8'h04, 0);
    @(negedge clk_sys_i);
    check(irq, 1'b1);
    bus(1, 5'h0c, 8'h14, 0);
    @(negedge clk_sys_i);
    check(irq, 1'b0);
    $display("test power down done");
    bus(1, 5'h04, 8'h00, 0);
    pulse(4);
    wait_on(1, 45000, n);
    check(n >= 39980 && n <= 41290, 1'b1);
    $display("test watchdog reset done");
    bus(1, 0, 8'h60, 0);
    pulse(5);
    wait_on(0, 45000, n);
    bus(0, 0, 0, 8'h60);
    bus(0, 5'h0c, 0, 8'h07);
    $display("test watchdog wake done");
    print_verdict();
  end
endmodule // tb_doze_idle_watchdog_control
